// ---- eac_cpu_model.sv ----
// Purpose: core model driving the controller's i/o register bus
// Assumes: requests launched 1 ns after the rising clock edge
// Notes: no request is issued while cpu_stall halts the core
`timescale 1ns/1ps
module eac_cpu_model (
    // clock and answers
    input wire logic clk_sys,
    input wire logic cpu_stall,
    input wire logic [7:0] io_rdata,
    // core side
    output eac_pkg::eac_io_req_t io_req,
    output logic global_irq_enable,
    output logic flash_selfprog_active
);
    logic rie; // software copy of the ready enable
    ////////////////////////////////////////////////////////////////
    initial begin
        io_req = '0;
        global_irq_enable = 1'b0;
        flash_selfprog_active = 1'b0;
        rie = 1'b0;
    end
    // release the bus in one assignment
    task automatic io_idle();
        io_req = '{1'b0, 1'b0, io_req.addr, io_req.wdata};
    endtask : io_idle
    // one write; held until the next request or io_idle, so back to back never double-drives
    task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
        io_req = '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        #1;
    endtask : io_wr
    // one read, data taken the cycle after
    task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
        io_req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        #1;
        d = io_rdata;
    endtask : io_rd
    // cycles the core stays halted, bounded
    task automatic stall_len(output int n);
        io_idle();
        n = 0;
        while (cpu_stall === 1'b1 && n < 16) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask : stall_len
    // poll until no write runs and flash is idle
    task automatic wait_idle();
        logic [7:0] c;
        c = 8'h02;
        while (c[1] !== 1'b0 || flash_selfprog_active) io_rd(eac_pkg::OFS_CTRL, c);
    endtask : wait_idle
    // unlocked byte write; interrupts kept off so the unlock cannot lapse
    task automatic nv_write(input logic [8:0] a, input logic [7:0] d, output int s);
        logic g;
        wait_idle();
        g = global_irq_enable;
        global_irq_enable = 1'b0;
        io_wr(eac_pkg::OFS_ADDR_HI, {7'h00, a[8]});
        io_wr(eac_pkg::OFS_ADDR_LO, a[7:0]);
        io_wr(eac_pkg::OFS_DATA, d);
        io_wr(eac_pkg::OFS_CTRL, {4'h0, rie, 3'h4});
        io_wr(eac_pkg::OFS_CTRL, {4'h0, rie, 3'h2});
        global_irq_enable = g;
        stall_len(s);
    endtask : nv_write
    // cycles from strobe until the strobe bit reads clear
    task automatic nv_done(input int s, output int n);
        logic [7:0] c;
        n = s;
        forever begin
            io_rd(eac_pkg::OFS_CTRL, c);
            if (c[1] !== 1'b1 || n > 64) break;
            n++;
        end
        io_idle();
    endtask : nv_done
    // byte read, returns the read stall
    task automatic nv_read(input logic [8:0] a, output logic [7:0] d, output int s);
        wait_idle();
        io_wr(eac_pkg::OFS_ADDR_HI, {7'h00, a[8]});
        io_wr(eac_pkg::OFS_ADDR_LO, a[7:0]);
        io_wr(eac_pkg::OFS_CTRL, {4'h0, rie, 3'h1});
        stall_len(s);
        io_rd(eac_pkg::OFS_DATA, d);
        io_idle();
    endtask : nv_read
endmodule : eac_cpu_model

// ---- eac_ctrl.sv ----
// Purpose: cpu-side access controller for the 512-byte data array
// Assumes: synchronous i/o requests, one per cycle, from the core
// Notes: the write engine keeps running through a reset if busy
`timescale 1ns/1ps
module eac_ctrl #(
    parameter int WR_TICKS = eac_pkg::WR_TICKS,
    parameter int RC_DIV = eac_pkg::RC_DIV
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // i/o register bus
    input wire eac_pkg::eac_io_req_t io_req,
    output logic [7:0] io_rdata,
    // core status
    input wire logic global_irq_enable,
    input wire logic flash_selfprog_active,
    // to the core
    output logic ready_irq,
    output logic cpu_stall
);
    // refuse counts the counters cannot hold
    if (WR_TICKS < 2 || WR_TICKS > 16383 || RC_DIV < 1 || RC_DIV > 63) begin : g_bad_par
        $error("eac_ctrl: timing parameter out of range");
    end

    ////////////////////////////////////////////////////////////////
    // address decode
    logic ctrl_wr, data_wr, alo_wr, ahi_wr;
    always_comb begin
        ctrl_wr = 1'b0;
        data_wr = 1'b0;
        alo_wr = 1'b0;
        ahi_wr = 1'b0;
        if (io_req.addr == eac_pkg::OFS_CTRL) begin
            ctrl_wr = io_req.wr;
        end else if (io_req.addr == eac_pkg::OFS_DATA) begin
            data_wr = io_req.wr;
        end else if (io_req.addr == eac_pkg::OFS_ADDR_LO) begin
            alo_wr = io_req.wr;
        end else if (io_req.addr == eac_pkg::OFS_ADDR_HI) begin
            ahi_wr = io_req.wr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // control bits and write engine
    logic rie_r, rie_nxt; // ready interrupt enable
    logic mwe_r, mwe_nxt; // master_write_unlock
    logic [2:0] unl_r, unl_nxt; // unlock countdown
    logic ws_r, ws_nxt; // write_strobe as software sees it
    logic busy_r, busy_nxt; // write engine running
    logic [5:0] div_r, div_nxt; // 1 MHz timebase divider
    logic [13:0] tick_r, tick_nxt; // timebase ticks in this write
    logic [7:0] wdat_r, wdat_nxt; // byte latched at write start
    logic wr_start, rd_start, wr_done, rc_tick;
    logic [7:0] data_r; // nv_data

    // strobes only act on a control write
    assign wr_start = ctrl_wr && io_req.wdata[eac_pkg::BIT_WS] && mwe_r
        && !busy_r && !flash_selfprog_active;
    assign rd_start = ctrl_wr && io_req.wdata[eac_pkg::BIT_RS] && !busy_r;
    assign rc_tick = busy_r && (div_r == 6'(RC_DIV - 1));
    assign wr_done = rc_tick && (tick_r == 14'(WR_TICKS - 1));

    always_comb begin
        rie_nxt = rie_r;
        mwe_nxt = mwe_r;
        unl_nxt = unl_r;
        ws_nxt = ws_r;
        busy_nxt = busy_r;
        div_nxt = div_r;
        tick_nxt = tick_r;
        wdat_nxt = wdat_r;
        // software side of the control register
        if (ctrl_wr) begin
            rie_nxt = io_req.wdata[eac_pkg::BIT_RIE];
        end
        // unlock: set only from clear, so a rewrite cannot stretch it
        if (ctrl_wr && io_req.wdata[eac_pkg::BIT_MWE] && !mwe_r) begin
            mwe_nxt = 1'b1;
            unl_nxt = 3'(eac_pkg::UNLOCK_CYC);
        end else if (mwe_r) begin
            unl_nxt = unl_r - 3'd1;
            if (unl_r == 3'd1) begin
                mwe_nxt = 1'b0;
            end
        end
        // write engine
        if (wr_start) begin
            ws_nxt = 1'b1;
            busy_nxt = 1'b1;
            div_nxt = 6'd0;
            tick_nxt = 14'd0;
            wdat_nxt = data_r;
        end else if (busy_r) begin
            div_nxt = rc_tick ? 6'd0 : div_r + 6'd1;
            if (rc_tick) begin
                tick_nxt = tick_r + 14'd1;
            end
            if (wr_done) begin
                busy_nxt = 1'b0;
                ws_nxt = 1'b0;
            end
        end
        // synchronous reset; a running write is left to finish
        if (!nrst) begin
            rie_nxt = 1'b0;
            mwe_nxt = 1'b0;
            unl_nxt = 3'd0;
            ws_nxt = 1'b0;
            if (busy_r) begin
                busy_nxt = !wr_done;
            end else begin
                busy_nxt = 1'b0;
                div_nxt = 6'd0;
                tick_nxt = 14'd0;
                wdat_nxt = eac_pkg::DATA_RST;
            end
        end
    end

    // register the control group
    always_ff @(posedge clk_sys) begin
        rie_r <= rie_nxt;
        mwe_r <= mwe_nxt;
        unl_r <= unl_nxt;
        ws_r <= ws_nxt;
        busy_r <= busy_nxt;
        div_r <= div_nxt;
        tick_r <= tick_nxt;
        wdat_r <= wdat_nxt;
    end

    ////////////////////////////////////////////////////////////////
    // address, data, read path
    logic [8:0] addr_r, addr_nxt; // nv_address_pair
    logic [7:0] data_nxt;
    logic rdp_r, rdp_nxt; // read data arrive next cycle
    logic [7:0] mem_rdata;

    always_comb begin
        addr_nxt = addr_r;
        data_nxt = data_r;
        rdp_nxt = rd_start;
        // address is frozen while the write runs
        if (alo_wr && !busy_r) begin
            addr_nxt[7:0] = io_req.wdata;
        end else if (ahi_wr && !busy_r) begin
            addr_nxt[8] = io_req.wdata[0];
        end
        // fetched byte beats a bus write, the core is stalled anyway
        if (rdp_r) begin
            data_nxt = mem_rdata;
        end else if (data_wr) begin
            data_nxt = io_req.wdata;
        end
        if (!nrst) begin
            // a running write still needs its address, so reset leaves it alone
            if (!busy_r) begin
                addr_nxt = eac_pkg::ADDR_RST;
            end
            data_nxt = eac_pkg::DATA_RST;
            rdp_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        addr_r <= addr_nxt;
        data_r <= data_nxt;
        rdp_r <= rdp_nxt;
    end

    // byte array, written when the timed write ends
    eac_mem #(
        .DEPTH(eac_pkg::DEPTH),
        .AW(eac_pkg::ADDR_W),
        .DW(eac_pkg::DATA_W)
    ) u_mem (
        .clk_sys(clk_sys),
        .wr_en(wr_done),
        .rd_en(rd_start),
        .addr(addr_r),
        .wdata(wdat_r),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////
    // read-back, stall and interrupt outputs
    logic [7:0] rdat_r, rdat_nxt;
    logic [2:0] stl_r, stl_nxt;
    logic stall_r, stall_nxt;
    logic irq_r, irq_nxt;

    always_comb begin
        rdat_nxt = rdat_r;
        // read-back mux; unmapped offsets read zero
        if (io_req.rd) begin
            if (io_req.addr == eac_pkg::OFS_CTRL) begin
                rdat_nxt = {4'h0, rie_r, mwe_r, ws_r, 1'b0};
            end else if (io_req.addr == eac_pkg::OFS_DATA) begin
                rdat_nxt = data_r;
            end else if (io_req.addr == eac_pkg::OFS_ADDR_LO) begin
                rdat_nxt = addr_r[7:0];
            end else if (io_req.addr == eac_pkg::OFS_ADDR_HI) begin
                rdat_nxt = {7'h00, addr_r[8]};
            end else begin
                rdat_nxt = 8'h00;
            end
        end
        // stall countdown
        stl_nxt = (stl_r != 3'd0) ? stl_r - 3'd1 : 3'd0;
        if (wr_start) begin
            stl_nxt = 3'(eac_pkg::STALL_WR_CYC);
        end else if (rd_start) begin
            stl_nxt = 3'(eac_pkg::STALL_RD_CYC);
        end
        // ready interrupt is a level, not a pulse
        irq_nxt = rie_nxt && global_irq_enable && !ws_nxt;
        if (!nrst) begin
            rdat_nxt = 8'h00;
            stl_nxt = 3'd0;
            irq_nxt = 1'b0;
        end
        stall_nxt = (stl_nxt != 3'd0);
    end

    always_ff @(posedge clk_sys) begin
        rdat_r <= rdat_nxt;
        stl_r <= stl_nxt;
        stall_r <= stall_nxt;
        irq_r <= irq_nxt;
    end

    assign io_rdata = rdat_r;
    assign cpu_stall = stall_r;
    assign ready_irq = irq_r;

    ////////////////////////////////////////////////////////////////
    // checks
    logic [19:0] hcnt_r; // cycles spent in the current write, wide enough for the largest legal count
    always_ff @(posedge clk_sys) begin
        hcnt_r <= wr_start ? 20'd1 : (busy_r ? hcnt_r + 20'd1 : 20'd0);
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_unlock_hold;
        mwe_r [*4] ##1 !mwe_r;
    endsequence
    sequence s_rd_stall;
        cpu_stall [*4] ##1 !cpu_stall;
    endsequence
    sequence s_wr_stall;
        cpu_stall [*2] ##1 !cpu_stall;
    endsequence

    a_unlock_timeout: assert property ($rose(mwe_r) |-> s_unlock_hold)
        else $error("unlock did not clear after four cycles");
    a_strobe_gated: assert property (wr_start |-> mwe_r && !busy_r)
        else $error("write started without unlock");
    a_flash_block: assert property (wr_start |-> !flash_selfprog_active)
        else $error("write started during flash programming");
    a_write_stall: assert property (wr_start |=> s_wr_stall)
        else $error("write stall not two cycles");
    a_read_stall: assert property (rd_start |=> s_rd_stall)
        else $error("read stall not four cycles");
    a_read_data: assert property (rd_start |=> ##1 data_r == $past(mem_rdata))
        else $error("fetched byte not in data register");
    a_addr_frozen: assert property (busy_r ##1 busy_r |-> $stable(addr_r))
        else $error("address changed during write");
    a_write_time: assert property (wr_done |-> hcnt_r == 20'(WR_TICKS * RC_DIV))
        else $error("write time wrong");
    a_strobe_clear: assert property (wr_done |=> !ws_r && !busy_r)
        else $error("strobe not cleared at end of write");
    a_irq_level: assert property (rie_r && global_irq_enable && !ws_r ##1
        rie_r && global_irq_enable && !ws_r |-> ready_irq)
        else $error("ready interrupt missing");
    a_hi_zero: assert property (io_req.rd && io_req.addr == eac_pkg::OFS_ADDR_HI
        |=> io_rdata[7:1] == 7'h00)
        else $error("unused address bits not zero");
endmodule : eac_ctrl

// ---- eac_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the access controller
// Assumes: shortened write timing set through the top parameters
// Notes: ordinary byte traffic is table driven, odd cases follow
`timescale 1ns/1ps
module eac_ctrl_tb_top;
    localparam int TK = 4; // shortened write ticks
    localparam int DV = 2; // shortened timebase divider
    localparam int WR_T = TK * DV; // write length in clocks
    logic clk_sys;
    logic nrst;
    eac_pkg::eac_io_req_t io_req;
    logic [7:0] io_rdata;
    logic global_irq_enable;
    logic flash_selfprog_active;
    logic ready_irq;
    logic cpu_stall;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int s;
    int n;
    logic [7:0] q;
    // address beside data; reading back must give the data
    logic [16:0] rows [4] = '{{9'h000, 8'hA5}, {9'h1FF, 8'h3C}, {9'h100, 8'h5A}, {9'h0FF, 8'hC3}};
    ////////////////////////////////////////////////////////////////
    eac_ctrl #(.WR_TICKS(TK), .RC_DIV(DV)) uut (.clk_sys(clk_sys), .nrst(nrst), .io_req(io_req),
        .io_rdata(io_rdata), .global_irq_enable(global_irq_enable),
        .flash_selfprog_active(flash_selfprog_active), .ready_irq(ready_irq), .cpu_stall(cpu_stall));
    eac_cpu_model cpu (.clk_sys(clk_sys), .cpu_stall(cpu_stall), .io_rdata(io_rdata), .io_req(io_req),
        .global_irq_enable(global_irq_enable), .flash_selfprog_active(flash_selfprog_active));
    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : tick
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        tick(6);
        nrst = 1'b1;
        // reset state, reserved bits, unmapped place
        cpu.io_rd(eac_pkg::OFS_CTRL, q);
        chk("ctrl", 16'h0000, 16'(q));
        chk("irq", 16'h0000, 16'(ready_irq));
        cpu.io_wr(eac_pkg::OFS_ADDR_HI, 8'hFF);
        cpu.io_rd(eac_pkg::OFS_ADDR_HI, q);
        chk("addr hi", 16'h0001, 16'(q));
        cpu.io_rd(6'h00, q);
        chk("unmapped", 16'h0000, 16'(q));
        // write every row, then read all back so aliasing shows
        foreach (rows[i]) begin
            cpu.nv_write(rows[i][16:8], rows[i][7:0], s);
            chk("wr stall", 16'h0002, 16'(s));
            cpu.nv_done(s, n);
            chk("wr time", 16'h0001, 16'(n >= WR_T - 1 && n <= WR_T + 1));
        end
        foreach (rows[i]) begin
            cpu.nv_read(rows[i][16:8], q, s);
            chk("rd data", 16'(rows[i][7:0]), 16'(q));
            chk("rd stall", 16'h0004, 16'(s));
        end
        // ready level follows enable, global enable and strobe
        cpu.rie = 1'b1;
        cpu.global_irq_enable = 1'b1;
        cpu.nv_write(9'h020, 8'h99, s);
        chk("irq busy", 16'h0000, 16'(ready_irq));
        cpu.nv_done(s, n);
        tick(2);
        chk("irq level", 16'h0001, 16'(ready_irq));
        cpu.io_rd(eac_pkg::OFS_CTRL, q);
        chk("ctrl rie", 16'h0008, 16'(q));
        cpu.global_irq_enable = 1'b0;
        tick(2);
        chk("irq gie off", 16'h0000, 16'(ready_irq));
        cpu.global_irq_enable = 1'b1;
        cpu.rie = 1'b0;
        cpu.io_wr(eac_pkg::OFS_CTRL, 8'h00);
        cpu.io_idle();
        tick(2);
        chk("irq rie off", 16'h0000, 16'(ready_irq));
        // address change and read strobe refused while busy
        cpu.nv_write(9'h055, 8'h77, s);
        cpu.io_wr(eac_pkg::OFS_ADDR_LO, 8'hAA);
        cpu.io_wr(eac_pkg::OFS_CTRL, 8'h01);
        cpu.stall_len(s);
        chk("busy rd stall", 16'h0000, 16'(s));
        cpu.nv_done(0, n);
        cpu.io_rd(eac_pkg::OFS_ADDR_LO, q);
        chk("frozen addr", 16'h0055, 16'(q));
        // unlock stands four cycles; a later strobe is ignored
        cpu.io_wr(eac_pkg::OFS_CTRL, 8'h04);
        cpu.io_rd(eac_pkg::OFS_CTRL, q);
        chk("unlock", 16'h0004, 16'(q));
        tick(2);
        cpu.io_rd(eac_pkg::OFS_CTRL, q);
        chk("unlock last", 16'h0004, 16'(q));
        cpu.io_rd(eac_pkg::OFS_CTRL, q);
        chk("unlock gone", 16'h0000, 16'(q));
        cpu.io_wr(eac_pkg::OFS_CTRL, 8'h02);
        cpu.stall_len(s);
        chk("late strobe", 16'h0000, 16'(s));
        // strobe on the last unlocked cycle still writes
        cpu.io_wr(eac_pkg::OFS_DATA, 8'h12);
        cpu.io_wr(eac_pkg::OFS_CTRL, 8'h04);
        cpu.io_idle();
        tick(3);
        cpu.io_wr(eac_pkg::OFS_CTRL, 8'h02);
        cpu.stall_len(s);
        chk("edge strobe", 16'h0002, 16'(s));
        cpu.nv_done(s, n);
        cpu.nv_read(9'h055, q, s);
        chk("edge data", 16'h0012, 16'(q));
        // no write while flash self-programming runs
        cpu.flash_selfprog_active = 1'b1;
        cpu.io_wr(eac_pkg::OFS_CTRL, 8'h04);
        cpu.io_wr(eac_pkg::OFS_CTRL, 8'h02);
        cpu.stall_len(s);
        chk("flash stall", 16'h0000, 16'(s));
        cpu.io_rd(eac_pkg::OFS_CTRL, q);
        chk("flash strobe", 16'h0000, 16'(q[1]));
        cpu.flash_selfprog_active = 1'b0;
        tick(4);
        // reset in mid-write: bits clear, the byte still lands
        cpu.nv_write(9'h1A0, 8'h6E, s);
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        cpu.io_rd(eac_pkg::OFS_CTRL, q);
        chk("ctrl after reset", 16'h0000, 16'(q));
        tick(WR_T);
        cpu.nv_read(9'h1A0, q, s);
        chk("write kept", 16'h006E, 16'(q));
        give_verdict();
    end
endmodule : eac_ctrl_tb_top

// ---- eac_mem.sv ----
// Purpose: byte array behind the access controller
// Assumes: one access per cycle; if both strobes come together the byte is written and the read returns the old byte
// Notes: read data come out of a register one cycle later
`timescale 1ns/1ps
module eac_mem #(
    parameter int DEPTH = eac_pkg::DEPTH,
    parameter int AW = eac_pkg::ADDR_W,
    parameter int DW = eac_pkg::DATA_W
) (
    // clock
    input wire logic clk_sys,
    // access port
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    // refuse a depth the address cannot cover
    if (DEPTH > (1 << AW)) begin : g_bad_depth
        $error("eac_mem: depth exceeds address range");
    end

    logic [DW-1:0] mem [DEPTH]; // storage, no reset by nature
    logic [DW-1:0] rdata_r; // registered read data

    // storage and registered read
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
        if (rd_en) begin
            rdata_r <= mem[addr];
        end
    end

    assign rdata = rdata_r;
endmodule : eac_mem

// ---- eac_pkg.sv ----
// Purpose: shared constants and types for the eeprom access controller
// Assumes: 40 MHz system clock, 1 MHz write timebase derived from it
// Notes: register offsets in the i/o space are local choices
// Function
// - nine-bit linear address selects one of 512 bytes
// - unused address and control bits read zero
// - address undefined; software loads it before access (the code resets it to ADDR_RST, zero, unless a write runs)
// - data register feeds writes, receives read bytes
// - ready interrupt level while enabled and strobe clear
// - master unlock self-clears after four clocks
// - write starts only with unlock still set
// - no write while flash self-programming active
// - hardware clears write strobe when write done
// - write timed by 8448 ticks of 1 MHz
// - write strobe stalls cpu two cycles
// - read strobe fetches at once, stalls four cycles
// - during write: reads ignored, address frozen
// - write in progress survives a reset
package eac_pkg;
    // array geometry
    localparam int ADDR_W = 9;
    localparam int DEPTH = 512;
    localparam int DATA_W = 8;
    localparam int IO_AW = 6;
    // register offsets in the i/o space
    localparam logic [5:0] OFS_CTRL = 6'h1C;
    localparam logic [5:0] OFS_DATA = 6'h1D;
    localparam logic [5:0] OFS_ADDR_LO = 6'h1E;
    localparam logic [5:0] OFS_ADDR_HI = 6'h1F;
    // control register bit positions
    localparam int BIT_RIE = 3;
    localparam int BIT_MWE = 2;
    localparam int BIT_WS = 1;
    localparam int BIT_RS = 0;
    // reset values
    localparam logic [8:0] ADDR_RST = 9'h000;
    localparam logic [7:0] DATA_RST = 8'h00;
    // timing
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int RC_CLK_HZ = 1_000_000;
    localparam int RC_DIV = SYS_CLK_HZ / RC_CLK_HZ;
    localparam int WR_TICKS = 8448;
    localparam int WR_TIME_US = 8500;
    localparam int UNLOCK_CYC = 4;
    localparam int STALL_WR_CYC = 2;
    localparam int STALL_RD_CYC = 4;
    // one i/o bus request from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } eac_io_req_t;
endpackage : eac_pkg
